// *** rtl/lcd_command_reset_decoder.sv ***
// module: command decoder, reset logic and display timing of the lcd driver
// Function
// - chip clear input low returns all control state to defaults
// - hardware reset: display off, normal polarity, normal segments, power bits zero
// - hardware reset clears partial serial shift register contents
// - reset cancels all-on, power save, rmw; indicator off, bits zero
// - reset sets start line, column and page address to zero
// - reset: normal com scan, modes exited, volume 100000, test off
// - software reset applies only defaults eleven through nineteen
// - during hardware reset timing stops, timing outputs forced high
// - transfers classified by select line and strobes, internal timing
// - serial bytes shift in msb first
// - command 1010111x sets display on from bit zero
// - display off while all-on active enters power saver
// - command 01xxxxxx loads display start line 0 to 63
// - command 1011xxxx loads page address 0 to 8
// - page changes never alter status read value
// - column address loaded by high and low nibble commands
// - ram write or non-rmw read increments column, stops at 83h, page untouched
// - status read: busy, segment dir, display off, reset, low zero
`timescale 1ns/10ps
module lcd_command_reset_decoder
#(
  parameter int INIT_CYCLES = lcd_cmd_pkg::INIT_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       chip_clear_input_n,
  input  wire logic       chip_select_n,
  input  wire logic       serial_mode,
  input  wire logic       enable_style,
  input  wire logic       cmd_data_select,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [7:0] data_in,
  input  wire logic       serial_clk,
  input  wire logic       serial_data,
  output logic      [7:0] data_out_q,
  output logic            data_out_en_n,
  output logic            ram_write_q,
  output logic      [7:0] ram_wdata_q,
  output logic            display_on_q,
  output logic            reverse_q,
  output logic            seg_reverse_q,
  output logic            all_on_q,
  output logic            power_save_q,
  output logic      [2:0] power_ctrl_q,
  output logic            bias_q,
  output logic            rmw_q,
  output logic      [1:0] indicator_q,
  output logic      [5:0] start_line_q,
  output logic      [3:0] page_q,
  output logic      [7:0] column_q,
  output logic            com_reverse_q,
  output logic      [2:0] ratio_q,
  output logic      [5:0] volume_q,
  output logic            test_mode_q,
  output logic            line_clock_out,
  output logic            frame_polarity_out,
  output logic            static_frame_polarity_out,
  output logic            display_blank_out_n
);

  // hardware reset covers both the system reset and the chip clear pin
  logic hw_rst;
  assign hw_rst = !rst_n || !chip_clear_input_n;

  // ------------------------------
  // strobe edge detection
  // ------------------------------
  logic rd_q, wr_q, sclk_q;
  logic rd_act, wr_act, rd_go, wr_go;
  // enable style: read_strobe_n carries enable, write_strobe_n the direction
  always_comb
  begin
    if (enable_style)
    begin
      rd_act = read_strobe_n && write_strobe_n;
      wr_act = read_strobe_n && !write_strobe_n;
    end
    else
    begin
      rd_act = !read_strobe_n;
      wr_act = !write_strobe_n;
    end
  end

  // act at strobe end so data is stable, like a latch on the trailing edge
  always_ff @(posedge clk)
  begin
    if (hw_rst)
    begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      sclk_q <= 1'b0;
    end
    else
    begin
      rd_q   <= rd_act && !chip_select_n && !serial_mode;
      wr_q   <= wr_act && !chip_select_n && !serial_mode;
      sclk_q <= serial_clk;
    end
  end
  assign rd_go = rd_q && !(rd_act && !chip_select_n);
  assign wr_go = wr_q && !(wr_act && !chip_select_n);

  // ------------------------------
  // serial input
  // ------------------------------
  logic [7:0] ser_byte;
  logic       ser_done;
  serial_shifter u_shift
  (
    .clk         (clk),
    .rst_n       (!hw_rst),
    .clr         (chip_select_n || !serial_mode),
    .sclk_rise   (serial_clk && !sclk_q),
    .sdata       (serial_data),
    .byte_q      (ser_byte),
    .byte_done_q (ser_done)
  );

  // ------------------------------
  // byte classification
  // ------------------------------
  logic       cmd_go, dat_go, dat_rd;
  logic [7:0] cmd_byte;
  logic       busy;
  assign cmd_byte = serial_mode ? ser_byte : data_in;
  // commands are taken only while not busy; a busy chip ignores them
  assign cmd_go  = !busy && !cmd_data_select && (serial_mode ? ser_done : wr_go);
  assign dat_go  = !busy && cmd_data_select && (serial_mode ? ser_done : wr_go);
  assign dat_rd  = !busy && rd_go && cmd_data_select;

  function automatic logic is_cmd(input logic [7:0] b, input logic [7:0] code,
                                  input int ignore);
    logic [7:0] m;
    m = 8'h_00ff << ignore;
    return (b & m) == (code & m);
  endfunction

  // the volume argument byte is data, so even an e2 pattern there is no reset
  logic soft_rst;
  logic vol_mode_q;
  assign soft_rst = cmd_go && !vol_mode_q && (cmd_byte == lcd_cmd_pkg::CMD_SOFT_RESET);

  // ------------------------------
  // initialization timer
  // ------------------------------
  logic [15:0] init_cnt_q;
  logic        init_q;
  // busy and reset status hold for the whole init window after either reset
  always_ff @(posedge clk)
  begin
    if (hw_rst)
    begin
      init_cnt_q <= 16'(INIT_CYCLES);
      init_q     <= 1'b1;
    end
    else if (soft_rst)
    begin
      init_cnt_q <= 16'(INIT_CYCLES);
      init_q     <= 1'b1;
    end
    else if (init_cnt_q != 16'h_0000)
    begin
      init_cnt_q <= init_cnt_q - 16'h_0001;
      init_q     <= (init_cnt_q != 16'h_0001);
    end
    else
      init_q <= 1'b0;
  end
  assign busy = init_q;

  // ------------------------------
  // display and power group (hardware reset only)
  // ------------------------------
  always_ff @(posedge clk)
  begin
    if (hw_rst)
    begin
      display_on_q  <= 1'b0;
      reverse_q     <= 1'b0;
      seg_reverse_q <= 1'b0;
      power_ctrl_q  <= 3'h_0000;
      bias_q        <= 1'b0;
      all_on_q      <= 1'b0;
      power_save_q  <= 1'b0;
    end
    else if (cmd_go && !vol_mode_q)              // soft reset leaves these
    begin
      if (is_cmd(cmd_byte, lcd_cmd_pkg::CMD_DISP_ONOFF, 1))
      begin
        display_on_q <= cmd_byte[0];
        power_save_q <= !cmd_byte[0] && all_on_q;
      end
      if (is_cmd(cmd_byte, lcd_cmd_pkg::CMD_SEG_DIR, 1))
        seg_reverse_q <= cmd_byte[0];
      if (is_cmd(cmd_byte, lcd_cmd_pkg::CMD_POLARITY, 1))
        reverse_q <= cmd_byte[0];
      if (is_cmd(cmd_byte, lcd_cmd_pkg::CMD_ALL_ON, 1))
      begin
        all_on_q     <= cmd_byte[0];
        power_save_q <= cmd_byte[0] && !display_on_q;
      end
      if (is_cmd(cmd_byte, 8'h_00a2, 1))
        bias_q <= cmd_byte[0];
      if (cmd_byte[7:3] == lcd_cmd_pkg::CMD_POWER)
        power_ctrl_q <= cmd_byte[2:0];
    end
  end

  // ------------------------------
  // addressing and mode group (both resets)
  // ------------------------------
  logic [7:0] rmw_col_q;
  logic       ratio_mode_q;
  logic       ram_acc;
  assign ram_acc = dat_go || dat_rd;

  always_ff @(posedge clk)
  begin
    if (hw_rst || soft_rst)
    begin
      rmw_q         <= 1'b0;
      indicator_q   <= 2'h_0000;
      start_line_q  <= 6'h_0000;
      column_q      <= 8'h_0000;
      page_q        <= 4'h_0000;
      com_reverse_q <= 1'b0;
      ratio_mode_q  <= 1'b0;
      ratio_q       <= lcd_cmd_pkg::RATIO_RST;
      vol_mode_q    <= 1'b0;
      volume_q      <= lcd_cmd_pkg::VOLUME_RST;
      test_mode_q   <= 1'b0;
      rmw_col_q     <= 8'h_0000;
    end
    else if (cmd_go && vol_mode_q)
    begin
      volume_q   <= cmd_byte[5:0];               // second byte of volume pair
      vol_mode_q <= 1'b0;
    end
    else if (cmd_go)
    begin
      if (cmd_byte[7:6] == lcd_cmd_pkg::CMD_START_LINE)
        start_line_q <= cmd_byte[5:0];
      if (cmd_byte[7:4] == lcd_cmd_pkg::CMD_PAGE && cmd_byte[3:0] <= lcd_cmd_pkg::PAGE_LAST)
        page_q <= cmd_byte[3:0];
      if (cmd_byte[7:4] == lcd_cmd_pkg::CMD_COL_HI && !rmw_q)
      begin
        column_q[7:4] <= cmd_byte[3:0];
      end
      if (cmd_byte[7:4] == lcd_cmd_pkg::CMD_COL_LO && !rmw_q)
      begin
        column_q[3:0] <= cmd_byte[3:0];
      end
      if (cmd_byte[7:4] == lcd_cmd_pkg::CMD_COM_DIR)
        com_reverse_q <= cmd_byte[3];
      if (cmd_byte[7:3] == lcd_cmd_pkg::CMD_RATIO)
      begin
        ratio_q      <= cmd_byte[2:0];
        ratio_mode_q <= 1'b0;
      end
      if (cmd_byte == lcd_cmd_pkg::CMD_VOL_MODE)
        vol_mode_q <= 1'b1;
      if (is_cmd(cmd_byte, lcd_cmd_pkg::CMD_INDICATOR, 1))
        indicator_q[0] <= cmd_byte[0];
      if (cmd_byte == lcd_cmd_pkg::CMD_RMW)
      begin
        rmw_q     <= 1'b1;
        rmw_col_q <= column_q;
      end
      if (cmd_byte == lcd_cmd_pkg::CMD_END && rmw_q)
      begin
        rmw_q    <= 1'b0;
        column_q <= rmw_col_q;
      end
      if (cmd_byte[7:4] == lcd_cmd_pkg::CMD_TEST[7:4])
        test_mode_q <= 1'b1;
    end
    // reads in rmw mode keep the column; saturate at the last column
    else if (ram_acc && !(rmw_q && dat_rd) && column_q < lcd_cmd_pkg::COL_LAST)
      column_q <= column_q + 8'h_0001;           // page never touched
  end

  // ------------------------------
  // ram write port and status read-back
  // ------------------------------
  always_ff @(posedge clk)
  begin
    if (hw_rst)
    begin
      ram_write_q <= 1'b0;
      ram_wdata_q <= 8'h_0000;
    end
    else
    begin
      ram_write_q <= dat_go;
      if (dat_go)
        ram_wdata_q <= cmd_byte;
    end
  end

  // status word has no page field, so page changes cannot show here
  always_ff @(posedge clk)
  begin
    if (hw_rst)
      data_out_q <= 8'h_0000;
    else if (rd_act && !cmd_data_select)
    begin
      data_out_q                     <= 8'h_0000;
      data_out_q[lcd_cmd_pkg::ST_BUSY]  <= busy;
      data_out_q[lcd_cmd_pkg::ST_SEG]   <= !seg_reverse_q;
      data_out_q[lcd_cmd_pkg::ST_OFF]   <= !display_on_q;
      data_out_q[lcd_cmd_pkg::ST_RESET] <= init_q;
    end
  end
  // drive the bus only during a parallel read; low enable means driving
  assign data_out_en_n = !(rd_act && !chip_select_n && !serial_mode);

  // ------------------------------
  // display timing generator
  // ------------------------------
  logic [3:0] div_q;
  logic [6:0] line_q;
  logic       cl_q, fr_q;
  // timing generator is frozen with its outputs high while held in reset
  always_ff @(posedge clk)
  begin
    if (hw_rst)
    begin
      div_q  <= 4'h_0000;
      line_q <= 7'h_0000;
      cl_q   <= 1'b1;
      fr_q   <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 4'h_0001;
      if (div_q == 4'(lcd_cmd_pkg::LINE_DIV - 1))
      begin
        cl_q <= !cl_q;
        if (cl_q)
        begin
          if (line_q == 7'(lcd_cmd_pkg::LINES_PER_FRM - 1))
          begin
            line_q <= 7'h_0000;
            fr_q   <= !fr_q;
          end
          else
            line_q <= line_q + 7'h_0001;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (hw_rst)
    begin
      line_clock_out            <= 1'b1;
      frame_polarity_out        <= 1'b1;
      static_frame_polarity_out <= 1'b1;
      display_blank_out_n       <= 1'b1;
    end
    else
    begin
      line_clock_out            <= cl_q;
      frame_polarity_out        <= fr_q;
      static_frame_polarity_out <= indicator_q[0] ? fr_q : 1'b0;
      display_blank_out_n       <= display_on_q; // low blanks the panel
    end
  end

endmodule // lcd_command_reset_decoder

// *** inc/lcd_cmd_pkg.sv ***
// package: command codes, reset values and timing for the lcd command decoder
package lcd_cmd_pkg;

  // ----------------------------------------
  // command encodings
  // ----------------------------------------
  localparam logic [7:0] CMD_DISP_ONOFF   = 8'h_00ae;  // low bit selects on/off
  localparam logic [1:0] CMD_START_LINE   = 2'h_0001;  // upper two bits
  localparam logic [3:0] CMD_PAGE         = 4'h_000b;  // upper nibble
  localparam logic [3:0] CMD_COL_HI       = 4'h_0001;
  localparam logic [3:0] CMD_COL_LO       = 4'h_0000;
  localparam logic [7:0] CMD_SEG_DIR      = 8'h_00a0;  // low bit reverses
  localparam logic [7:0] CMD_POLARITY     = 8'h_00a6;
  localparam logic [7:0] CMD_ALL_ON       = 8'h_00a4;
  localparam logic [7:0] CMD_RMW          = 8'h_00e0;
  localparam logic [7:0] CMD_END          = 8'h_00ee;
  localparam logic [7:0] CMD_SOFT_RESET   = 8'h_00e2;
  localparam logic [3:0] CMD_COM_DIR      = 4'h_000c;
  localparam logic [4:0] CMD_POWER        = 5'h_0005;
  localparam logic [4:0] CMD_RATIO        = 5'h_0004;
  localparam logic [7:0] CMD_VOL_MODE     = 8'h_0081;
  localparam logic [7:0] CMD_INDICATOR    = 8'h_00ac;
  localparam logic [7:0] CMD_TEST         = 8'h_00f0;  // upper nibble f enters test

  // ----------------------------------------
  // reset values and address limits
  // ----------------------------------------
  localparam logic [5:0] VOLUME_RST       = 6'h_0020;
  localparam logic [7:0] COL_LAST         = 8'h_0083;
  localparam logic [3:0] PAGE_LAST        = 4'h_0008;
  localparam logic [2:0] RATIO_RST        = 3'h_0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS        = 100;
  localparam int INIT_NS       = 1000;   // internal initialization time
  localparam int INIT_CYCLES   = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int LINE_DIV      = 16;     // display timing divider for line clock
  localparam int LINES_PER_FRM = 65;

  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int ST_BUSY  = 7;
  localparam int ST_SEG   = 6;
  localparam int ST_OFF   = 5;
  localparam int ST_RESET = 4;

endpackage

// *** rtl/serial_shifter.sv ***
// module: msb-first serial byte assembler
`timescale 1ns/10ps
module serial_shifter
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       sclk_rise,
  input  wire logic       sdata,
  output logic      [7:0] byte_q,
  output logic            byte_done_q
);

  logic [6:0] shift_q;
  logic [2:0] count_q;

  // ------------------------------
  // shift register
  // ------------------------------
  // hardware reset or chip deselect drops a partial byte
  always_ff @(posedge clk)
  begin
    if (!rst_n || clr)
    begin
      shift_q     <= 7'h_0000;
      count_q     <= 3'h_0000;
      byte_done_q <= 1'b0;
      byte_q      <= 8'h_0000;
    end
    else
    begin
      byte_done_q <= 1'b0;
      if (sclk_rise)
      begin
        shift_q <= {shift_q[5:0], sdata};   // first bit in ends up as bit 7
        count_q <= count_q + 3'h_0001;
        if (count_q == 3'h_0007)
        begin
          byte_q      <= {shift_q, sdata};
          byte_done_q <= 1'b1;
        end
      end
    end
  end

endmodule // serial_shifter

// *** dv/lcd_command_reset_decoder_assertions.sv ***
// checker: port-level assertions for the lcd command decoder
`timescale 1ns/10ps
module lcd_command_reset_decoder_assertions
#(
  parameter int INIT_CYCLES = 10
)
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       chip_clear_input_n,
  input wire logic       chip_select_n,
  input wire logic       serial_mode,
  input wire logic       enable_style,
  input wire logic       cmd_data_select,
  input wire logic       read_strobe_n,
  input wire logic [7:0] data_out_q,
  input wire logic       data_out_en_n,
  input wire logic       ram_write_q,
  input wire logic       display_on_q,
  input wire logic       seg_reverse_q,
  input wire logic       all_on_q,
  input wire logic       power_save_q,
  input wire logic [5:0] start_line_q,
  input wire logic [3:0] page_q,
  input wire logic [7:0] column_q,
  input wire logic [5:0] volume_q,
  input wire logic       line_clock_out,
  input wire logic       frame_polarity_out,
  input wire logic       static_frame_polarity_out,
  input wire logic       display_blank_out_n
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a strobe-style status read in progress
  sequence rd_s;
    !serial_mode && !enable_style && !chip_select_n && !read_strobe_n && !cmd_data_select;
  endsequence
  reset_vals_a: assert property (!chip_clear_input_n |=> !display_on_q && page_q == 4'h0
    && column_q == 8'h00 && start_line_q == 6'h00 && volume_q == lcd_cmd_pkg::VOLUME_RST)
    else $error("state not at defaults after reset");
  timing_high_a: assert property (!chip_clear_input_n |=> line_clock_out && display_blank_out_n
    && frame_polarity_out && static_frame_polarity_out)
    else $error("timing outputs not high in reset");
  blank_follow_a: assert property (display_on_q |=> display_blank_out_n)
    else $error("blanking output low while display on");
  column_top_a: assert property (column_q <= lcd_cmd_pkg::COL_LAST)
    else $error("column above last");
  page_top_a: assert property (page_q <= lcd_cmd_pkg::PAGE_LAST)
    else $error("page above last");
  page_keep_a: assert property (ram_write_q |-> $stable(page_q))
    else $error("ram access moved the page");
  read_drive_a: assert property (rd_s |-> !data_out_en_n)
    else $error("data bus not driven during read");
  status_bits_a: assert property (rd_s ##1 rd_s |-> data_out_q[3:0] == 4'h0
    && data_out_q[6] == !$past(seg_reverse_q) && data_out_q[5] == !$past(display_on_q))
    else $error("status byte wrong");
  save_entry_a: assert property ($rose(power_save_q) |-> all_on_q && !display_on_q)
    else $error("power save without all-on and display off");
endmodule // lcd_command_reset_decoder_assertions

bind lcd_command_reset_decoder lcd_command_reset_decoder_assertions
  #(.INIT_CYCLES(INIT_CYCLES)) chk_inst (.clk(clk), .rst_n(rst_n),
  .chip_clear_input_n(chip_clear_input_n), .chip_select_n(chip_select_n),
  .serial_mode(serial_mode), .enable_style(enable_style), .cmd_data_select(cmd_data_select),
  .read_strobe_n(read_strobe_n), .data_out_q(data_out_q), .data_out_en_n(data_out_en_n),
  .ram_write_q(ram_write_q), .display_on_q(display_on_q), .seg_reverse_q(seg_reverse_q),
  .all_on_q(all_on_q), .power_save_q(power_save_q), .start_line_q(start_line_q),
  .page_q(page_q), .column_q(column_q), .volume_q(volume_q), .line_clock_out(line_clock_out),
  .frame_polarity_out(frame_polarity_out),
  .static_frame_polarity_out(static_frame_polarity_out),
  .display_blank_out_n(display_blank_out_n));

// *** dv/host_bus_model.sv ***
// partner: host processor bus model, parallel and serial transfers
`timescale 1ns/10ps
module host_bus_model
(
  input  wire logic clk,
  output logic       chip_clear_input_n,
  output logic       chip_select_n,
  output logic       serial_mode,
  output logic       enable_style,
  output logic       cmd_data_select,
  output logic       read_strobe_n,
  output logic       write_strobe_n,
  output logic [7:0] data_in,
  output logic       serial_clk,
  output logic       serial_data
);
  // power-on goes through the reset pin, state is unknown until then
  initial
  begin
    {chip_clear_input_n, serial_mode, enable_style, cmd_data_select, serial_clk} = 5'h00;
    {chip_select_n, read_strobe_n, write_strobe_n, serial_data} = 4'hf;
    data_in = 8'h00;
    repeat (3) @(posedge clk);
    #1 chip_clear_input_n = 1'b1;
  end
  // every change lands just after a rising edge
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic set_mode(input logic s, input logic e);
    step();
    serial_mode = s;
    enable_style = e;
    read_strobe_n = !e;
    write_strobe_n = !e;
  endtask
  task automatic clear;
    step();
    chip_clear_input_n = 1'b0;
    step();
    step();
    chip_clear_input_n = 1'b1;
  endtask
  // write: strobe low pulse, or direction low then enable high
  task automatic wr(input logic cd, input logic [7:0] b);
    step();
    cmd_data_select = cd;
    data_in = b;
    chip_select_n = 1'b0;
    write_strobe_n = 1'b0;
    if (enable_style)
    begin
      step();
      read_strobe_n = 1'b1;
    end
    step();
    if (enable_style) read_strobe_n = 1'b0;
    else write_strobe_n = 1'b1;
    step();
    chip_select_n = 1'b1;
    data_in = ~b; // released bus does not keep the old byte
    step();
    step();
  endtask
  task automatic rd_hold(input int n);
    step();
    cmd_data_select = 1'b0;
    chip_select_n = 1'b0;
    write_strobe_n = 1'b1;
    if (enable_style)
    begin
      step();
      read_strobe_n = 1'b1;
    end
    else read_strobe_n = 1'b0;
    repeat (n) step();
  endtask
  task automatic rd_end;
    read_strobe_n = !enable_style;
    step();
    chip_select_n = 1'b1;
    write_strobe_n = !enable_style;
    step();
  endtask
  // serial clock idles low between frames
  task automatic ser(input logic cd, input logic [7:0] b, input int n);
    step();
    chip_select_n = 1'b0;
    cmd_data_select = cd;
    for (int i = 7; i > 7 - n; i--)
    begin
      serial_data = b[i];
      step();
      serial_clk = 1'b1;
      step();
      serial_clk = 1'b0;
    end
    step();
    step();
    chip_select_n = 1'b1;
    serial_data = ~serial_data;
    step();
    step();
  endtask
endmodule // host_bus_model

// *** dv/lcd_command_reset_decoder_bench.sv ***
// testbench: drives commands through the host model and checks decoder state
`timescale 1ns/10ps
module lcd_command_reset_decoder_bench;
  localparam int INIT = 12;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clr_n, cs_n, ser_m, en_s, cds, rd_n, wr_n, sclk, sdat, oe_n, rw, ind1, sfr, fr, lck, blk_n;
  logic don_o, rev_o, seg_o, allon_o, ps_o, bias_o, rmw_o, com_o, tst_o;
  logic [7:0] din, dout, wdat, col_o;
  logic [5:0] sl_o, vol_o;
  logic [3:0] pg_o;
  logic [2:0] pwr_o, rat_o;
  logic [1:0] ind_o;
  logic don, segr, allon, psave, rmw, comr, tst, volm, rev, bias;
  logic [2:0] pwr, rat;
  logic [5:0] sl, vol;
  logic [3:0] pg;
  logic [7:0] col;
  logic [39:0] nq[$];
  logic [39:0] n;
  logic [7:0] wd_q[$];
  int fails = 0;
  int n_tests = 0;
  event note_ev;
  wire [38:0] act = {don_o, seg_o, allon_o, ps_o, pwr_o, rmw_o, ind_o, sl_o, pg_o, col_o,
                     com_o, rat_o, vol_o, tst_o};
  initial
  begin
    forever #50 clk = ~clk;
  end
  host_bus_model host_bus_model_inst (.clk(clk), .chip_clear_input_n(clr_n),
    .chip_select_n(cs_n), .serial_mode(ser_m), .enable_style(en_s), .cmd_data_select(cds),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(din), .serial_clk(sclk),
    .serial_data(sdat));
  lcd_command_reset_decoder #(.INIT_CYCLES(INIT)) lcd_command_reset_decoder_inst (.clk(clk),
    .rst_n(rst_n), .chip_clear_input_n(clr_n), .chip_select_n(cs_n), .serial_mode(ser_m),
    .enable_style(en_s), .cmd_data_select(cds), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .data_in(din), .serial_clk(sclk), .serial_data(sdat), .data_out_q(dout),
    .data_out_en_n(oe_n), .ram_write_q(rw), .ram_wdata_q(wdat), .display_on_q(don_o),
    .reverse_q(rev_o), .seg_reverse_q(seg_o), .all_on_q(allon_o), .power_save_q(ps_o),
    .power_ctrl_q(pwr_o), .bias_q(bias_o), .rmw_q(rmw_o), .indicator_q(ind_o),
    .start_line_q(sl_o), .page_q(pg_o), .column_q(col_o), .com_reverse_q(com_o),
    .ratio_q(rat_o), .volume_q(vol_o), .test_mode_q(tst_o), .line_clock_out(lck),
    .frame_polarity_out(fr), .static_frame_polarity_out(sfr), .display_blank_out_n(blk_n));
  // ------------------------------
  // checking and bookkeeping
  // ------------------------------
  task automatic check(input logic [38:0] seen, input logic [38:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic note(input logic k, input logic [38:0] v);
    nq.push_back({k, v});
    -> note_ev;
  endtask
  // oldest note against the outputs it describes; kind 1 is a status byte
  always @(note_ev)
  begin
    n = nq.pop_front();
    check(n[39] ? {31'h0, dout} : act, n[38:0]);
  end
  // every ram write pulse must carry the oldest data byte sent
  always @(negedge clk)
  begin
    if (rw === 1'b1) check({31'h0, wdat}, {31'h0, wd_q.pop_front()});
  end
  task automatic defaults(input logic hw);
    if (hw) {don, segr, allon, psave, pwr, rev, bias} = 9'h00;
    {rmw, sl, pg, col, comr, rat, tst, volm} = '0;
    vol = lcd_cmd_pkg::VOLUME_RST;
  endtask
  // expected decode first, so a data byte is queued before its pulse
  task automatic cmd(input logic cd, input logic [7:0] b);
    if (volm) {volm, vol} = {1'b0, b[5:0]};
    else if (cd)
    begin
      wd_q.push_back(b);
      if (col < 8'h83) col++;
    end
    else casez (b)
      8'b1010_111?: {don, psave} = {b[0], psave | (!b[0] & allon)};
      8'b1010_000?: segr = b[0];
      8'b1010_011?: rev = b[0];
      8'b1010_001?: bias = b[0];
      8'b1010_010?: {allon, psave} = {b[0], psave | (b[0] & !don)};
      8'b01??_????: sl = b[5:0];
      8'b1011_????: if (b[3:0] <= 4'h8) pg = b[3:0];
      8'b0001_????: col = {b[3:0], col[3:0]};
      8'b0000_????: col = {col[7:4], b[3:0]};
      8'b0010_1???: pwr = b[2:0];
      8'b0010_0???: rat = b[2:0];
      8'b1100_????: comr = b[3];
      8'b1111_????: tst = 1'b1;
      8'h81: volm = 1'b1;
      8'he0: rmw = 1'b1;
      8'he2: defaults(1'b0);
      default: ;
    endcase
    if (ser_m) host_bus_model_inst.ser(cd, b, 8);
    else host_bus_model_inst.wr(cd, b);
  endtask
  function automatic logic [38:0] expv();
    return {don, segr, allon, psave, pwr, rmw, 2'b00, sl, pg, col, comr, rat, vol, tst};
  endfunction
  // ------------------------------
  // main sequence: strobe, enable and serial modes in turn
  // ------------------------------
  initial
  begin
    void'($urandom(91));
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (INIT + 2) @(posedge clk);
    for (int m = 0; m < 3; m++)
    begin
      host_bus_model_inst.set_mode(m == 2, m == 1);
      if (m == 2) host_bus_model_inst.ser(1'b0, 8'hff, 4); // partial byte dropped
      host_bus_model_inst.clear();
      defaults(1'b1);
      if (m < 2)
      begin
        host_bus_model_inst.rd_hold(2);
        note(1'b1, 39'hf0);
        host_bus_model_inst.rd_end();
        host_bus_model_inst.wr(1'b0, 8'haf); // refused while busy
      end
      repeat (INIT) @(posedge clk);
      #1 note(1'b0, expv());
      check({37'h0, rev_o, bias_o}, {37'h0, rev, bias});
      cmd(1'b0, 8'haf);
      cmd(1'b0, {2'b01, 6'($urandom)});
      cmd(1'b0, {4'hb, 4'($urandom_range(8))});
      cmd(1'b0, {4'hb, 4'(9 + $urandom_range(6))}); // out-of-range page refused
      note(1'b0, expv());
      if (m < 2)
      begin
        host_bus_model_inst.rd_hold(2);
        note(1'b1, 39'h40);
        host_bus_model_inst.rd_end();
      end
      cmd(1'b0, 8'h18);
      cmd(1'b0, 8'h01);
      repeat (3) cmd(1'b1, 8'($urandom));
      note(1'b0, expv());
      cmd(1'b0, 8'ha5);
      cmd(1'b0, 8'hae);
      note(1'b0, expv());
      cmd(1'b0, 8'ha7);
      cmd(1'b0, 8'ha3);
      cmd(1'b0, 8'ha1);
      cmd(1'b0, {5'h05, 3'($urandom)});
      cmd(1'b0, 8'hc8);
      cmd(1'b0, {5'h04, 3'($urandom)});
      cmd(1'b0, 8'h81);
      cmd(1'b0, 8'($urandom));
      cmd(1'b0, 8'he0);
      cmd(1'b0, 8'hf0);
      note(1'b0, expv());
      cmd(1'b0, 8'he2);
      repeat (INIT + 2) @(posedge clk);
      #1 note(1'b0, expv());
      check({37'h0, rev_o, bias_o}, {37'h0, rev, bias});
    end
    test_done();
  end
  // hang guard, far beyond the under one thousand cycles of the sequence
  initial
  begin
    #2_000_000;
    fails++;
    test_done();
  end
endmodule // lcd_command_reset_decoder_bench
